// ---- design/flpcu_ctrl.sv ----
// flash program control and unlock: apb registers, unlock check, launcher
// assumes flash answers in clk domain; low voltage detect comes from a pin
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01: start settable only when interlocked and unlocked
// RULE_02: start launches the selected operation
// RULE_03: hardware clears start when operation ends
// RULE_04: interlock steers start versus selector writes
// RULE_05: selector writable only with interlock clear
// RULE_06: error flag set on failed sequence
// RULE_07: low voltage flag set on detected droop; code sets it only while in FLPCU_ST_WAIT
// RULE_08: flags cleared only by no-operation start
// RULE_09: control fields reset only at power-on
// RULE_10: chip erase only with zero protect boundary
// RULE_11: region erase only when region unprotected
// RULE_12: page erase suppressed on protected page
// RULE_13: row program skipped on protected row
// RULE_14: quad program skipped when protected
// RULE_15: word program when unprotected, zero does nothing
// RULE_16: word program nop under always-on ecc
// RULE_17: key register write-only, reads zero
// RULE_18: key writes form the unlock sequence
// RULE_19: unimplemented control bits read zero
// RULE_20: low address bits ignored per operation
// RULE_21: quad data is four words, word zero low
// RULE_22: row data fetched from source address
// RULE_23: exact key order, any deviation re-arms
// RULE_24: software polls start then checks flags
module flpcu_ctrl
  import flpcu_pkg::*;
(
  input wire logic clk, // 125 MHz clock
  input wire logic resetn, // system reset, sync, active low
  input wire logic por_resetn, // power-on reset, sync, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic low_voltage_pin, // asynchronous low voltage detect
  input wire flpcu_rsp_t flash_rsp, // flash answer
  output flpcu_req_t flash_req, // flash request
  output logic busy // operation running
);
  // launcher states
  typedef enum logic [1:0] {
    FLPCU_ST_IDLE = 2'b00,
    FLPCU_ST_CHECK = 2'b01,
    FLPCU_ST_WAIT = 2'b10
  } flpcu_state_t;
  // unlock progress
  typedef enum logic [1:0] {
    FLPCU_UL_NONE = 2'b00,
    FLPCU_UL_FIRST = 2'b01,
    FLPCU_UL_OPEN = 2'b10
  } flpcu_unlock_t;

  flpcu_state_t state_reg; // launcher state
  flpcu_unlock_t unlock_reg; // unlock progress
  logic start_reg; // start bit
  logic ilock_reg; // interlock bit
  logic werr_reg; // operation error flag
  logic lverr_reg; // low voltage error flag
  logic [3:0] op_reg; // operation selector
  logic [31:0] addr_reg; // target address
  logic [31:0] data_reg [4]; // program data words
  logic [31:0] src_reg; // row source address
  logic [23:0] prot_reg; // protect boundary
  logic [1:0] ecc_reg; // ecc configuration
  logic lv_meta_reg; // synchroniser first stage
  logic lv_sync_reg; // synchroniser second stage
  logic pready_reg; // ready flop
  logic pslverr_reg; // error flop
  logic [31:0] prdata_reg; // read data flop
  flpcu_req_t req_reg; // request flop
  logic access; // completing apb access
  logic wr_ctrl; // write to control
  logic mapped; // address decodes
  logic start_set; // accepted start
  logic blocked; // target protected or invalid
  logic [31:0] ctrl_word; // control read view
  logic [31:0] rd_next; // read mux
  logic [127:0] quad_data; // concatenated data

  assign access = psel & penable & pready_reg;
  assign wr_ctrl = access & pwrite & (paddr == FLPCU_OFS_CTRL);
  // start only with interlock and fresh unlock, never while running
  assign start_set = wr_ctrl & pwdata[FLPCU_BIT_START] & ilock_reg
    & (unlock_reg == FLPCU_UL_OPEN) & ~start_reg; // RULE_01 RULE_04

  // address decode
  always_comb begin
    case (paddr)
      FLPCU_OFS_CTRL, FLPCU_OFS_KEY, FLPCU_OFS_ADDR, FLPCU_OFS_DATA0,
      FLPCU_OFS_DATA1, FLPCU_OFS_DATA2, FLPCU_OFS_DATA3, FLPCU_OFS_SRC,
      FLPCU_OFS_PROT, FLPCU_OFS_ECC: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // control view, unimplemented bits zero
  always_comb begin
    ctrl_word = FLPCU_RST_WORD; // RULE_19
    ctrl_word[FLPCU_BIT_START] = start_reg;
    ctrl_word[FLPCU_BIT_ILOCK] = ilock_reg;
    ctrl_word[FLPCU_BIT_WERR] = werr_reg;
    ctrl_word[FLPCU_BIT_LVERR] = lverr_reg;
    ctrl_word[FLPCU_OP_MSB:0] = op_reg;
  end

  // read mux
  always_comb begin
    case (paddr)
      FLPCU_OFS_CTRL: rd_next = ctrl_word;
      FLPCU_OFS_KEY: rd_next = FLPCU_RST_WORD; // RULE_17
      FLPCU_OFS_ADDR: rd_next = addr_reg;
      FLPCU_OFS_DATA0: rd_next = data_reg[0];
      FLPCU_OFS_DATA1: rd_next = data_reg[1];
      FLPCU_OFS_DATA2: rd_next = data_reg[2];
      FLPCU_OFS_DATA3: rd_next = data_reg[3];
      FLPCU_OFS_SRC: rd_next = src_reg;
      FLPCU_OFS_PROT: rd_next = {8'h00, prot_reg};
      FLPCU_OFS_ECC: rd_next = {30'h0, ecc_reg};
      default: rd_next = FLPCU_RST_WORD;
    endcase
  end

  // apb answer: one wait state per access
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= FLPCU_RST_WORD;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
      if (psel & penable & ~pready_reg & ~pwrite) begin
        prdata_reg <= rd_next;
      end
    end
  end

  // unlock check: two keys back to back, any other access re-arms
  always_ff @(posedge clk) begin
    if (!resetn) begin
      unlock_reg <= FLPCU_UL_NONE;
    end else if (access) begin
      if (pwrite && paddr == FLPCU_OFS_KEY && pwdata == FLPCU_KEY_FIRST) begin
        unlock_reg <= FLPCU_UL_FIRST; // RULE_18 RULE_23
      end else if (pwrite && paddr == FLPCU_OFS_KEY && pwdata == FLPCU_KEY_SECOND
                   && unlock_reg == FLPCU_UL_FIRST) begin
        unlock_reg <= FLPCU_UL_OPEN; // RULE_18 RULE_23
      end else begin
        unlock_reg <= FLPCU_UL_NONE; // RULE_23
      end
    end
  end

  // interlock and selector, power-on reset only
  always_ff @(posedge clk) begin
    if (!por_resetn) begin
      ilock_reg <= 1'b0; // RULE_09
      op_reg <= FLPCU_RST_WORD[3:0]; // RULE_09
    end else if (wr_ctrl) begin
      ilock_reg <= pwdata[FLPCU_BIT_ILOCK];
      if (!ilock_reg) begin
        op_reg <= pwdata[FLPCU_OP_MSB:0]; // RULE_04 RULE_05
      end
    end
  end

  // other software registers, power-on reset only
  always_ff @(posedge clk) begin
    if (!por_resetn) begin
      addr_reg <= FLPCU_RST_WORD;
      src_reg <= FLPCU_RST_WORD;
      prot_reg <= FLPCU_RST_WORD[23:0];
      ecc_reg <= FLPCU_RST_ECC;
      for (int i = 0; i < 4; i++) begin
        data_reg[i] <= FLPCU_RST_WORD;
      end
    end else if (access && pwrite) begin
      case (paddr)
        FLPCU_OFS_ADDR: addr_reg <= pwdata;
        FLPCU_OFS_DATA0: data_reg[0] <= pwdata;
        FLPCU_OFS_DATA1: data_reg[1] <= pwdata;
        FLPCU_OFS_DATA2: data_reg[2] <= pwdata;
        FLPCU_OFS_DATA3: data_reg[3] <= pwdata;
        FLPCU_OFS_SRC: src_reg <= pwdata;
        FLPCU_OFS_PROT: prot_reg <= pwdata[23:0];
        FLPCU_OFS_ECC: ecc_reg <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // low voltage pin synchroniser
  always_ff @(posedge clk) begin
    if (!por_resetn) begin
      lv_meta_reg <= 1'b0;
      lv_sync_reg <= 1'b0;
    end else begin
      lv_meta_reg <= low_voltage_pin;
      lv_sync_reg <= lv_meta_reg;
    end
  end

  // protection and code validity of the selected operation
  always_comb begin
    case (op_reg)
      FLPCU_OP_CHIP, FLPCU_OP_REGION: blocked = (prot_reg != 24'h0); // RULE_10 RULE_11
      FLPCU_OP_PAGE, FLPCU_OP_ROW, FLPCU_OP_QUAD, FLPCU_OP_WORD:
        blocked = (addr_reg[23:0] < prot_reg); // RULE_12 RULE_13 RULE_14 RULE_15
      FLPCU_OP_NONE: blocked = 1'b0;
      default: blocked = 1'b1; // reserved codes
    endcase
  end

  // data order: word zero least significant
  assign quad_data = {data_reg[3], data_reg[2], data_reg[1], data_reg[0]}; // RULE_21

  // launcher: start bit, flags and flash request
  always_ff @(posedge clk) begin
    if (!por_resetn) begin
      state_reg <= FLPCU_ST_IDLE; // RULE_09
      start_reg <= 1'b0; // RULE_09
      werr_reg <= 1'b0; // RULE_09
      lverr_reg <= 1'b0; // RULE_09
      req_reg <= '0;
    end else begin
      req_reg.start <= 1'b0;
      case (state_reg)
        FLPCU_ST_IDLE: begin
          if (start_set) begin
            start_reg <= 1'b1; // RULE_02
            state_reg <= FLPCU_ST_CHECK;
          end
        end
        FLPCU_ST_CHECK: begin
          if (op_reg == FLPCU_OP_NONE) begin
            werr_reg <= 1'b0; // RULE_08
            lverr_reg <= 1'b0; // RULE_08
            start_reg <= 1'b0; // RULE_03 RULE_15
            state_reg <= FLPCU_ST_IDLE;
          end else if (blocked) begin
            werr_reg <= 1'b1; // RULE_06
            start_reg <= 1'b0; // RULE_03
            state_reg <= FLPCU_ST_IDLE;
          end else if (op_reg == FLPCU_OP_WORD && ecc_reg == FLPCU_ECC_ALWAYS) begin
            start_reg <= 1'b0; // RULE_16
            state_reg <= FLPCU_ST_IDLE;
          end else begin
            req_reg.start <= 1'b1; // RULE_02
            req_reg.op <= op_reg;
            case (op_reg)
              FLPCU_OP_PAGE: req_reg.addr <= {addr_reg[31:12], 12'h000}; // RULE_20
              FLPCU_OP_ROW: req_reg.addr <= {addr_reg[31:9], 9'h000}; // RULE_20
              FLPCU_OP_QUAD: req_reg.addr <= {addr_reg[31:4], 4'h0}; // RULE_20
              FLPCU_OP_WORD: req_reg.addr <= {addr_reg[31:2], 2'h0}; // RULE_20
              default: req_reg.addr <= FLPCU_RST_WORD;
            endcase
            req_reg.data <= (op_reg == FLPCU_OP_WORD) ?
              {96'h0, data_reg[0]} : quad_data; // RULE_21
            req_reg.src <= src_reg; // RULE_22
            req_reg.skip_ecc <= (op_reg == FLPCU_OP_WORD); // RULE_16
            state_reg <= FLPCU_ST_WAIT;
          end
        end
        FLPCU_ST_WAIT: begin
          if (lv_sync_reg) begin
            lverr_reg <= 1'b1; // RULE_07
          end
          if (flash_rsp.done) begin
            if (flash_rsp.fail) begin
              werr_reg <= 1'b1; // RULE_06
            end
            start_reg <= 1'b0; // RULE_03
            state_reg <= FLPCU_ST_IDLE;
          end
        end
        default: state_reg <= FLPCU_ST_IDLE;
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign flash_req = req_reg;
  assign busy = start_reg;

  // start only rises through an accepted unlocked write
  a_start_gate: assert property (@(posedge clk) disable iff (!por_resetn || !resetn)
    $rose(start_reg) |-> $past(ilock_reg) && $past(unlock_reg) == FLPCU_UL_OPEN) // RULE_01
    else $error("start set without interlock or unlock");
  // launch reaches the flash two cycles after the start write
  a_start_launch: assert property (@(posedge clk) disable iff (!por_resetn)
    req_reg.start |-> $past(start_reg) && $past(op_reg) != FLPCU_OP_NONE) // RULE_02
    else $error("flash launch without start");
  // start falls on the done answer
  a_start_clear: assert property (@(posedge clk) disable iff (!por_resetn)
    state_reg == FLPCU_ST_WAIT && flash_rsp.done |=> !start_reg) // RULE_03
    else $error("start not cleared at completion");
  // selector frozen while interlocked
  a_sel_frozen: assert property (@(posedge clk) disable iff (!por_resetn)
    ilock_reg |=> $stable(op_reg)) // RULE_04 RULE_05
    else $error("selector changed under interlock");
  // failed sequence raises error flag
  a_fail_flag: assert property (@(posedge clk) disable iff (!por_resetn)
    state_reg == FLPCU_ST_WAIT && flash_rsp.done && flash_rsp.fail |=> werr_reg) // RULE_06
    else $error("error flag missed a failure");
  // flags fall only through a no-operation run
  a_flag_clear: assert property (@(posedge clk) disable iff (!por_resetn)
    $fell(werr_reg) || $fell(lverr_reg) |->
      $past(state_reg) == FLPCU_ST_CHECK && $past(op_reg) == FLPCU_OP_NONE) // RULE_08
    else $error("error flag cleared outside no-operation");
  // protected chip erase never launched
  a_chip_protect: assert property (@(posedge clk) disable iff (!por_resetn)
    state_reg == FLPCU_ST_CHECK && op_reg == FLPCU_OP_CHIP && prot_reg != 24'h0
      |=> !req_reg.start && werr_reg) // RULE_10
    else $error("protected chip erase launched");
  // key reads answer zero
  a_key_zero: assert property (@(posedge clk) disable iff (!resetn)
    access && !pwrite && paddr == FLPCU_OFS_KEY |-> prdata_reg == 32'h0) // RULE_17
    else $error("key register read nonzero");
  // page erase address low bits zero
  a_page_mask: assert property (@(posedge clk) disable iff (!por_resetn)
    req_reg.start && req_reg.op == FLPCU_OP_PAGE |-> req_reg.addr[11:0] == 12'h000) // RULE_20
    else $error("page erase address not aligned");
  // word program nop under always-on ecc
  a_word_nop: assert property (@(posedge clk) disable iff (!por_resetn)
    state_reg == FLPCU_ST_CHECK && op_reg == FLPCU_OP_WORD && ecc_reg == FLPCU_ECC_ALWAYS
      && !blocked |=> !req_reg.start && !start_reg) // RULE_16
    else $error("word program ran under always-on ecc");
  // accepted start write reaches the check state next cycle
  sequence s_start_taken;
    start_set ##1 (start_reg && state_reg == FLPCU_ST_CHECK);
  endsequence
  // launch pulse toward the flash while the launcher waits
  sequence s_launch_seen;
    req_reg.start && state_reg == FLPCU_ST_WAIT;
  endsequence
  // a runnable selection launches right after the check
  a_start_walk: assert property (@(posedge clk) disable iff (!por_resetn) // RULE_02
    s_start_taken ##0 (op_reg != FLPCU_OP_NONE && !blocked
      && !(op_reg == FLPCU_OP_WORD && ecc_reg == FLPCU_ECC_ALWAYS)) |=> s_launch_seen)
    else $error("accepted start did not launch");
  // low voltage while waiting raises its flag
  a_lv_flag: assert property (@(posedge clk) disable iff (!por_resetn) // RULE_07
    state_reg == FLPCU_ST_WAIT && lv_sync_reg |=> lverr_reg)
    else $error("low voltage flag missed");
  // system reset alone leaves interlock and selector alone
  a_sysrst_keep: assert property (@(posedge clk) disable iff (!por_resetn) // RULE_09
    !resetn && !access |=> $stable(ilock_reg) && $stable(op_reg))
    else $error("control field lost on system reset");
endmodule : flpcu_ctrl
`default_nettype wire

// ---- design/flpcu_pkg.sv ----
// package for the flash program control and unlock block
// assumes one clock, apb register access and a flash macro on the far side
package flpcu_pkg;
  // register byte offsets (low twelve bits of paddr)
  localparam logic [11:0] FLPCU_OFS_CTRL = 12'ha00; // flash_program_control
  localparam logic [11:0] FLPCU_OFS_KEY = 12'ha10; // flash_unlock_key
  localparam logic [11:0] FLPCU_OFS_ADDR = 12'ha20; // flash_target_address
  localparam logic [11:0] FLPCU_OFS_DATA0 = 12'ha30; // program_data_word0
  localparam logic [11:0] FLPCU_OFS_DATA1 = 12'ha40; // program data word 1
  localparam logic [11:0] FLPCU_OFS_DATA2 = 12'ha50; // program data word 2
  localparam logic [11:0] FLPCU_OFS_DATA3 = 12'ha60; // program data word 3
  localparam logic [11:0] FLPCU_OFS_SRC = 12'ha70; // row_source_address
  localparam logic [11:0] FLPCU_OFS_PROT = 12'ha80; // page_protect_boundary
  localparam logic [11:0] FLPCU_OFS_ECC = 12'hab0; // flash_ecc_config
  // control field positions
  localparam int FLPCU_BIT_START = 15; // operation start
  localparam int FLPCU_BIT_ILOCK = 14; // start_interlock_enable
  localparam int FLPCU_BIT_WERR = 13; // operation_error_flag
  localparam int FLPCU_BIT_LVERR = 12; // low_voltage_error_flag
  localparam int FLPCU_OP_MSB = 3; // operation_selector top bit
  // reset values
  localparam logic [31:0] FLPCU_RST_WORD = 32'h0000_0000; // all registers except ecc configuration
  localparam logic [1:0] FLPCU_RST_ECC = 2'h0; // ecc configuration
  // unlock key words, arbitrary values
  localparam logic [31:0] FLPCU_KEY_FIRST = 32'h1234_5678;
  localparam logic [31:0] FLPCU_KEY_SECOND = 32'h8765_4321;
  // ecc configurations
  localparam logic [1:0] FLPCU_ECC_ALWAYS = 2'h0; // ecc always on
  localparam logic [1:0] FLPCU_ECC_DYNAMIC = 2'h1; // dynamic ecc
  // operation selector codes
  typedef enum logic [3:0] {
    FLPCU_OP_NONE = 4'h0,
    FLPCU_OP_WORD = 4'h1,
    FLPCU_OP_QUAD = 4'h2,
    FLPCU_OP_ROW = 4'h3,
    FLPCU_OP_PAGE = 4'h4,
    FLPCU_OP_REGION = 4'h5,
    FLPCU_OP_CHIP = 4'h7
  } flpcu_op_t;
  // request to the flash macro
  typedef struct packed {
    logic start; // one-cycle launch
    logic [3:0] op; // operation code
    logic [31:0] addr; // target address, ignored bits zero
    logic [127:0] data; // quad data, word 0 low
    logic [31:0] src; // row source address
    logic skip_ecc; // write without ecc bits
  } flpcu_req_t;
  // answer from the flash macro
  typedef struct packed {
    logic done; // one-cycle completion
    logic fail; // sequence failed
  } flpcu_rsp_t;
endpackage : flpcu_pkg

// ---- testbench/flpcu_flash_model.sv ----
// flash macro stand-in: answers each launch with one done pulse
// assumes the controller clock and at most one launch in flight
`timescale 1ns/1ps
`default_nettype none
module flpcu_flash_model
  import flpcu_pkg::*;
(
  input wire logic clk, // shared clock
  input wire logic por_resetn, // power-on reset, active low
  input wire flpcu_req_t flash_req, // launch from controller
  input wire logic fail_cmd, // report failure on next done
  input wire logic slow, // long busy time
  output flpcu_rsp_t flash_rsp, // done pulse with fail
  output logic [7:0] req_count, // launches seen
  output flpcu_req_t last_req // fields of last launch
);
  logic [4:0] wait_reg; // cycles left, zero when idle
  // count down after each launch, then pulse done once
  always_ff @(posedge clk) begin
    flash_rsp <= '0;
    if (!por_resetn) begin
      wait_reg <= '0;
      req_count <= '0;
      last_req <= '0;
    end else if (flash_req.start) begin
      wait_reg <= slow ? 5'd20 : 5'd2;
      req_count <= req_count + 8'd1;
      last_req <= flash_req;
    end else if (wait_reg == 5'd1) begin
      wait_reg <= '0;
      flash_rsp.done <= 1'b1;
      flash_rsp.fail <= fail_cmd;
    end else if (wait_reg != 5'd0) begin
      wait_reg <= wait_reg - 5'd1;
    end
  end
endmodule : flpcu_flash_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for the flash program control block
// assumes the flash model stands on the far side of flash_req
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import flpcu_pkg::*;
  typedef struct {
    logic [3:0] op; // selector code
    logic [23:0] prot; // protect boundary
    logic [1:0] ecc; // ecc configuration
    logic fail; // flash reports failure
    logic req; // launch expected
    logic err; // error flag raised
    logic [31:0] addr; // expected target address
  } flpcu_row_t;
  logic clk = 1'b0; // bench clock
  logic resetn = 1'b0; // system reset
  logic por_resetn = 1'b0; // power-on reset
  logic psel = 1'b0; // apb select
  logic penable = 1'b0; // apb access
  logic pwrite = 1'b0; // apb direction
  logic [11:0] paddr = 12'h000; // apb address
  logic [31:0] pwdata = 32'h0; // apb write data
  logic [31:0] prdata; // apb read data
  logic pready; // apb ready
  logic pslverr; // apb error
  logic lv_pin = 1'b0; // low voltage detect
  logic fail_cmd = 1'b0; // model failure
  logic slow = 1'b0; // model speed
  logic busy; // operation running
  flpcu_req_t flash_req; // launch
  flpcu_rsp_t flash_rsp; // answer
  flpcu_req_t last_req; // last launch fields
  logic [7:0] req_count; // launches seen
  logic [7:0] cnt; // count before a test
  logic [31:0] rd; // last read data
  logic se; // last pslverr
  logic sticky; // expected error flag
  int err_total = 0; // mismatches
  int samples_checked = 0; // comparisons
  flpcu_row_t rows[13] = '{
    '{4'h1, 24'h0, 2'h1, 1'b0, 1'b1, 1'b0, 32'h0012_3ffc},
    '{4'h1, 24'h0, 2'h0, 1'b0, 1'b0, 1'b0, 32'h0},
    '{4'h2, 24'h0, 2'h1, 1'b0, 1'b1, 1'b0, 32'h0012_3ff0},
    '{4'h3, 24'h0, 2'h1, 1'b0, 1'b1, 1'b0, 32'h0012_3e00},
    '{4'h4, 24'h0, 2'h1, 1'b0, 1'b1, 1'b0, 32'h0012_3000},
    '{4'h5, 24'h0, 2'h1, 1'b0, 1'b1, 1'b0, 32'h0},
    '{4'h7, 24'h0, 2'h1, 1'b0, 1'b1, 1'b0, 32'h0},
    '{4'h7, 24'h100, 2'h1, 1'b0, 1'b0, 1'b1, 32'h0},
    '{4'h0, 24'h0, 2'h1, 1'b0, 1'b0, 1'b0, 32'h0},
    '{4'h4, 24'h200000, 2'h1, 1'b0, 1'b0, 1'b1, 32'h0},
    '{4'h6, 24'h0, 2'h1, 1'b0, 1'b0, 1'b1, 32'h0},
    '{4'h2, 24'h0, 2'h1, 1'b1, 1'b1, 1'b1, 32'h0012_3ff0},
    '{4'h0, 24'h0, 2'h1, 1'b0, 1'b0, 1'b0, 32'h0}};

  flpcu_ctrl flpcu_ctrl_i (.clk(clk), .resetn(resetn), .por_resetn(por_resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .low_voltage_pin(lv_pin),
    .flash_rsp(flash_rsp), .flash_req(flash_req), .busy(busy));
  flpcu_flash_model flpcu_flash_model_i (.clk(clk), .por_resetn(por_resetn),
    .flash_req(flash_req), .fail_cmd(fail_cmd), .slow(slow), .flash_rsp(flash_rsp),
    .req_count(req_count), .last_req(last_req));

  // free-running clock, 8 ns period
  always #4 clk = ~clk;

  // count and report one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready as this edge samples it; data taken at that same edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1, "pready");
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // select, interlock, unlock, start, then poll until done
  task automatic run_op(input logic [3:0] op);
    int n;
    n = 0;
    apb(1'b1, FLPCU_OFS_CTRL, {28'h0, op});
    apb(1'b1, FLPCU_OFS_CTRL, {28'h000_0400, op});
    apb(1'b1, FLPCU_OFS_KEY, FLPCU_KEY_FIRST);
    apb(1'b1, FLPCU_OFS_KEY, FLPCU_KEY_SECOND);
    apb(1'b1, FLPCU_OFS_CTRL, {28'h0000_c00, op});
    do begin
      apb(1'b0, FLPCU_OFS_CTRL, 32'h0);
      n++;
    end while (rd[15] !== 1'b0 && n < 40);
    if (n >= 40) chk(32'h0, 32'h1, "poll");
  endtask : run_op

  // print counts and verdict, then stop
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // watchdog for a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    chk(32'h0, 32'h1, "watchdog");
    summarize();
  end

  // main sequence: table rows, then hand-written cases
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    por_resetn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++)
      apb(1'b1, FLPCU_OFS_DATA0 + 12'(16 * i), 32'ha5a5_0000 + 32'(i));
    apb(1'b1, FLPCU_OFS_SRC, 32'h2000_0100);
    sticky = 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, FLPCU_OFS_PROT, {8'h0, rows[i].prot});
      apb(1'b1, FLPCU_OFS_ECC, {30'h0, rows[i].ecc});
      apb(1'b1, FLPCU_OFS_ADDR, 32'h0012_3fff);
      fail_cmd <= rows[i].fail;
      cnt = req_count;
      run_op(rows[i].op);
      sticky = (rows[i].op == 4'h0) ? 1'b0 : (sticky | rows[i].err);
      chk(rd, 32'h4000 | (32'(sticky) << 13) | 32'(rows[i].op), "ctrl");
      chk(32'(req_count - cnt), 32'(rows[i].req), "launch");
      chk(32'(busy), 32'h0, "busy");
      if (rows[i].req && rows[i].op < 4'h5)
        chk(last_req.addr, rows[i].addr, "addr");
      if (rows[i].req && rows[i].op == 4'h1)
        chk(32'(last_req.skip_ecc), 32'h1, "skip");
      if (rows[i].req && rows[i].op == 4'h2)
        chk(last_req.data[127:96], 32'ha5a5_0003, "quad");
      if (rows[i].req && rows[i].op == 4'h3)
        chk(last_req.src, 32'h2000_0100, "src");
      $display("row %0d done", i);
    end
    fail_cmd <= 1'b0;
    apb(1'b1, FLPCU_OFS_CTRL, 32'hffff_0ff0);
    apb(1'b0, FLPCU_OFS_CTRL, 32'h0);
    chk(rd, 32'h0, "unused bits");
    apb(1'b1, FLPCU_OFS_CTRL, 32'h4003);
    apb(1'b1, FLPCU_OFS_CTRL, 32'h4005);
    apb(1'b0, FLPCU_OFS_CTRL, 32'h0);
    chk(rd, 32'h4003, "sel locked");
    cnt = req_count;
    apb(1'b1, FLPCU_OFS_KEY, FLPCU_KEY_FIRST);
    apb(1'b0, FLPCU_OFS_CTRL, 32'h0);
    apb(1'b1, FLPCU_OFS_KEY, FLPCU_KEY_SECOND);
    apb(1'b1, FLPCU_OFS_CTRL, 32'hc003);
    apb(1'b0, FLPCU_OFS_CTRL, 32'h0);
    chk(rd, 32'h4003, "broken key");
    apb(1'b1, FLPCU_OFS_CTRL, 32'hc003);
    apb(1'b0, FLPCU_OFS_CTRL, 32'h0);
    chk(rd, 32'h4003, "no key");
    chk(32'(req_count - cnt), 32'h0, "no launch");
    $display("interlock tests done");
    lv_pin <= 1'b1;
    slow <= 1'b1;
    run_op(4'h3);
    chk(rd, 32'h5003, "low volt");
    lv_pin <= 1'b0;
    slow <= 1'b0;
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    apb(1'b0, FLPCU_OFS_CTRL, 32'h0);
    chk(rd, 32'h5003, "sys reset");
    run_op(4'h0);
    chk(rd, 32'h4000, "flag clear");
    $display("flag tests done");
    apb(1'b0, FLPCU_OFS_KEY, 32'h0);
    chk(rd, 32'h0, "key read");
    apb(1'b0, 12'hff0, 32'h0);
    chk(32'(se), 32'h1, "unmapped");
    por_resetn <= 1'b0;
    repeat (2) @(posedge clk);
    por_resetn <= 1'b1;
    @(posedge clk);
    apb(1'b0, FLPCU_OFS_CTRL, 32'h0);
    chk(rd, FLPCU_RST_WORD, "por");
    $display("reset tests done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
